/* File: rtl/fifo_buffer.sv */
`timescale 1ns/1ns
module fifo_buffer #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != CW'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        wr_next    = wr_reg;
        rd_next    = rd_reg;
        count_next = count_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            count_reg <= '0;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            count_reg <= count_next;
        end
    end

    // storage needs no reset; out_data_o is used only while count is non-zero, and rd_reg then points at a written slot
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

endmodule : fifo_buffer

/* File: rtl/rom_verify_modes.sv */
`timescale 1ns/1ns
// Summary of operation
// - readout takes port1/port2 address, drives data.
// - compare straps select compare; starts on release.
// - strobe period 3 units, one byte each.
// - internal addresses; compare instead of output.
// - every 16 compares, show group result.
// - readout only for unprotected contents.
// - first byte is address 0; strobe advances.
// - latch 3 units after strobe; store mismatch.
// - failing result stays low for later groups.
// - after last byte, pulse program-store strobe.
module rom_verify_modes (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        program_store_strobe_n_i,
    output logic             program_store_strobe_n_o,
    output logic             program_store_strobe_oe_o,
    input  wire logic        address_latch_strobe_i,
    output logic             address_latch_strobe_o,
    output logic             address_latch_strobe_oe_o,
    input  wire logic        external_access_select_n_i,
    input  wire logic [7:0]  port0_i,
    output logic      [7:0]  port0_o,
    output logic             port0_oe_o,
    input  wire logic [7:0]  port1_i,
    input  wire logic [7:0]  port2_i,
    input  wire logic        rom_protected_i,
    output logic      [15:0] rom_addr_o,
    input  wire logic [7:0]  rom_data_i,
    output logic             verify_result_pin_o,
    output logic             verify_done_o
);
    import rom_verify_pkg::*;

    logic [rom_verify_pkg::SYNC_W-1:0] sync1_reg;
    logic [rom_verify_pkg::SYNC_W-1:0] sync2_reg;
    logic        rstn_s;
    logic        program_store_strobe_s;
    logic        ale_s;
    logic        ea_s;
    logic [7:0]  p0_s;
    logic [7:0]  p1_s;
    logic [7:0]  p2_s;

    // every pin except rom_protected_i and rom_data_i passes two flops before anything looks at it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sync1_reg <= {1'h0, 27'h7FFFFFF};
            sync2_reg <= {1'h0, 27'h7FFFFFF};
        end else begin
            sync1_reg <= {reset_pin_n_i, program_store_strobe_n_i,
                          address_latch_strobe_i,
                          external_access_select_n_i,
                          port2_i, port1_i, port0_i};
            sync2_reg <= sync1_reg;
        end
    end
    assign {rstn_s, program_store_strobe_s, ale_s, ea_s, p2_s, p1_s, p0_s} = sync2_reg;

    mode_t       mode_reg, mode_next;
    logic        strap_rdo_reg, strap_rdo_next;
    logic        strap_cmp_reg, strap_cmp_next;
    logic        prot_reg, prot_next;
    logic [1:0]  phase_reg, phase_next;
    logic [15:0] ptr_reg, ptr_next;
    logic        gen_done_reg, gen_done_next;
    logic        pend_reg, pend_next;
    logic [7:0]  exp_reg, exp_next;
    logic        last_reg, last_next;
    logic [3:0]  grp_cnt_reg, grp_cnt_next;
    logic        grp_err_reg, grp_err_next;
    logic        result_reg, result_next;
    logic [15:0] rom_addr_reg, rom_addr_next;
    logic [7:0]  p0_out_reg, p0_out_next;
    logic        p0_oe_reg, p0_oe_next;
    logic        ale_reg, ale_next;
    logic        ale_oe_reg, ale_oe_next;
    logic        program_store_strobe_reg, program_store_strobe_next;
    logic        program_store_strobe_oe_reg, program_store_strobe_oe_next;
    logic        done_reg, done_next;
    logic        mismatch;

    logic        push;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [23:0] fifo_out_data;

    // the buffer lets the compare stage lag the strobe without losing bytes
    fifo_buffer #(
        .WIDTH (rom_verify_pkg::FIFO_WIDTH),
        .DEPTH (rom_verify_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (ref_clk_i),
        .rst_i       (sys_rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({ptr_reg, p0_s}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign push = (mode_reg == MODE_COMPARE) && !gen_done_reg
                  && (phase_reg == PHASE_LATCH) && fifo_in_ready;
    assign fifo_out_ready = !pend_reg
                  && ((mode_reg == MODE_COMPARE) || (mode_reg == MODE_DONE));
    assign mismatch = pend_reg && (rom_data_i != exp_reg);

    always_comb begin
        mode_next      = mode_reg;
        strap_rdo_next = strap_rdo_reg;
        strap_cmp_next = strap_cmp_reg;
        prot_next      = prot_reg;
        phase_next     = phase_reg;
        ptr_next       = ptr_reg;
        gen_done_next  = gen_done_reg;
        pend_next      = pend_reg;
        exp_next       = exp_reg;
        last_next      = last_reg;
        grp_cnt_next   = grp_cnt_reg;
        grp_err_next   = grp_err_reg;
        result_next    = result_reg;
        rom_addr_next  = rom_addr_reg;
        p0_out_next    = p0_out_reg;
        p0_oe_next     = 1'h0;
        done_next      = done_reg;
        case (mode_reg)
            MODE_RESET: begin
                // straps are caught only while the reset pin is held
                strap_rdo_next = (program_store_strobe_s == RDO_PROGRAM_STORE_STROBE_N) && (ale_s == RDO_ALE)
                                 && (ea_s == RDO_EA_N);
                strap_cmp_next = (program_store_strobe_s == CMP_PROGRAM_STORE_STROBE_N) && (ale_s == CMP_ALE)
                                 && (ea_s == CMP_EA_N);
                prot_next      = rom_protected_i;
                phase_next     = PHASE_FIRST;
                ptr_next       = ADDR_FIRST;
                gen_done_next  = 1'h0;
                grp_cnt_next   = GROUP_FIRST;
                grp_err_next   = 1'h0;
                result_next    = RESULT_PASS;
                done_next      = 1'h0;
                if (rstn_s) begin
                    if (strap_cmp_reg) begin
                        mode_next = MODE_COMPARE;
                    end else if (strap_rdo_reg) begin
                        mode_next = MODE_READOUT;
                    end else begin
                        mode_next = MODE_RUN;
                    end
                end
            end
            MODE_READOUT: begin
                rom_addr_next = {p2_s, p1_s};
                p0_out_next   = rom_data_i;
                // protected contents never reach port 0
                p0_oe_next    = !prot_reg;
            end
            MODE_COMPARE, MODE_DONE: begin
                if (mode_reg == MODE_DONE || gen_done_reg) begin
                    phase_next = (phase_reg == PHASE_LAST) ? PHASE_FIRST
                                 : phase_reg + 2'h1;
                end else if (phase_reg != PHASE_LAST) begin
                    phase_next = phase_reg + 2'h1;
                end else if (push) begin
                    // a full buffer stretches the period instead of dropping
                    phase_next = PHASE_FIRST;
                    if (ptr_reg == ADDR_LAST) begin
                        gen_done_next = 1'h1;
                    end else begin
                        ptr_next = ptr_reg + 16'h0001;
                    end
                end
                if (pend_reg) begin
                    pend_next = 1'h0;
                    if (grp_cnt_reg == GROUP_LAST) begin
                        if (grp_err_reg || mismatch) begin
                            result_next = RESULT_FAIL;
                        end
                        grp_err_next = 1'h0;
                    end else begin
                        grp_err_next = grp_err_reg || mismatch;
                    end
                    grp_cnt_next = grp_cnt_reg + 4'h1;
                    if (last_reg) begin
                        mode_next = MODE_DONE;
                        done_next = 1'h1;
                        phase_next = PHASE_FIRST;
                    end
                end else if (fifo_out_valid) begin
                    pend_next     = 1'h1;
                    rom_addr_next = fifo_out_data[23:8];
                    exp_next      = fifo_out_data[7:0];
                    last_next     = (fifo_out_data[23:8] == ADDR_LAST);
                end
            end
            MODE_RUN: begin
                done_next = 1'h0;
            end
            default: begin
                mode_next = MODE_RESET;
            end
        endcase
        if (!rstn_s) begin
            mode_next = MODE_RESET;
            pend_next = 1'h0;
            last_next = 1'h0;
        end
    end

    // pin drivers follow the next state so each output is a plain flop
    always_comb begin
        ale_oe_next  = (mode_next == MODE_COMPARE) || (mode_next == MODE_DONE);
        program_store_strobe_oe_next = ale_oe_next;
        ale_next     = (mode_next == MODE_COMPARE) && !gen_done_next
                       && (phase_next == PHASE_FIRST);
        program_store_strobe_next    = !((mode_next == MODE_DONE)
                       && (phase_next == PHASE_FIRST));
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode_reg      <= MODE_RESET;
            strap_rdo_reg <= 1'h0;
            strap_cmp_reg <= 1'h0;
            prot_reg      <= 1'h1;
            phase_reg     <= PHASE_FIRST;
            ptr_reg       <= ADDR_FIRST;
            gen_done_reg  <= 1'h0;
            pend_reg      <= 1'h0;
            exp_reg       <= 8'h00;
            last_reg      <= 1'h0;
            grp_cnt_reg   <= GROUP_FIRST;
            grp_err_reg   <= 1'h0;
            result_reg    <= RESULT_PASS;
            rom_addr_reg  <= ADDR_FIRST;
            p0_out_reg    <= 8'h00;
            p0_oe_reg     <= 1'h0;
            ale_reg       <= 1'h0;
            ale_oe_reg    <= 1'h0;
            program_store_strobe_reg      <= 1'h1;
            program_store_strobe_oe_reg   <= 1'h0;
            done_reg      <= 1'h0;
        end else begin
            mode_reg      <= mode_next;
            strap_rdo_reg <= strap_rdo_next;
            strap_cmp_reg <= strap_cmp_next;
            prot_reg      <= prot_next;
            phase_reg     <= phase_next;
            ptr_reg       <= ptr_next;
            gen_done_reg  <= gen_done_next;
            pend_reg      <= pend_next;
            exp_reg       <= exp_next;
            last_reg      <= last_next;
            grp_cnt_reg   <= grp_cnt_next;
            grp_err_reg   <= grp_err_next;
            result_reg    <= result_next;
            rom_addr_reg  <= rom_addr_next;
            p0_out_reg    <= p0_out_next;
            p0_oe_reg     <= p0_oe_next;
            ale_reg       <= ale_next;
            ale_oe_reg    <= ale_oe_next;
            program_store_strobe_reg      <= program_store_strobe_next;
            program_store_strobe_oe_reg   <= program_store_strobe_oe_next;
            done_reg      <= done_next;
        end
    end

    assign program_store_strobe_n_o  = program_store_strobe_reg;
    assign program_store_strobe_oe_o = program_store_strobe_oe_reg;
    assign address_latch_strobe_o    = ale_reg;
    assign address_latch_strobe_oe_o = ale_oe_reg;
    assign port0_o                   = p0_out_reg;
    assign port0_oe_o                = p0_oe_reg;
    assign rom_addr_o                = rom_addr_reg;
    assign verify_result_pin_o       = result_reg;
    assign verify_done_o             = done_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_strobe_low_time: assert property (
        $rose(address_latch_strobe_o) |=> !address_latch_strobe_o [*2])
        else $error("strobe high too long or period too short");

    a_readout_only_open: assert property (
        port0_oe_o |-> ($past(mode_reg) == MODE_READOUT) && !prot_reg)
        else $error("port 0 driven outside unprotected readout");

    a_readout_addr: assert property (
        (mode_reg == MODE_READOUT && mode_next == MODE_READOUT)
        |=> rom_addr_o == $past({p2_s, p1_s}))
        else $error("readout address not taken from ports 1 and 2");

    a_compare_entry: assert property (
        (mode_reg == MODE_RESET && rstn_s && strap_cmp_reg)
        |=> mode_reg == MODE_COMPARE && ptr_reg == ADDR_FIRST)
        else $error("compare mode not entered at reset release");

    a_pointer_step: assert property (
        (push && ptr_reg != ADDR_LAST) |=> ptr_reg == $past(ptr_reg) + 16'h1)
        else $error("address pointer did not advance by one");

    // a reset pin taken low mid-period ends the period without a latch
    a_latch_timing: assert property (
        disable iff (sys_rst_i || !rstn_s)
        $rose(address_latch_strobe_o) && fifo_in_ready |-> ##2 push)
        else $error("port 0 not latched three units after strobe");

    a_group_result: assert property (
        $fell(verify_result_pin_o)
        |-> $past(pend_reg) && $past(grp_cnt_reg) == GROUP_LAST)
        else $error("result changed outside a group boundary");

    a_result_sticky: assert property (
        (!verify_result_pin_o && mode_reg != MODE_RESET)
        |=> !verify_result_pin_o || $past(mode_next) == MODE_RESET)
        else $error("failing result released");

    a_mismatch_kept: assert property (
        (mismatch && grp_cnt_reg != GROUP_LAST) |=> grp_err_reg)
        else $error("mismatch not stored");

    a_end_pulses: assert property (
        (mode_reg == MODE_DONE && rstn_s)
        |-> ##[0:2] !program_store_strobe_n_o)
        else $error("no end strobe after last byte");

endmodule : rom_verify_modes

/* File: rtl/rom_verify_pkg.sv */
package rom_verify_pkg;

    // one clock_period_unit is one period of the system clock
    localparam int CLK_PERIOD_NS     = 20;
    localparam int CLP_NS            = 20;
    localparam int ALE_PERIOD_CLP    = 3;
    localparam int LATCH_DELAY_CLP   = 3;
    // least times, rounded up to whole cycles
    localparam int ALE_PERIOD_CYCLES =
        (ALE_PERIOD_CLP * CLP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCH_CYCLES      =
        (LATCH_DELAY_CLP * CLP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0]  PHASE_FIRST = 2'h0;
    localparam logic [1:0]  PHASE_LAST  = 2'(ALE_PERIOD_CYCLES - 1);
    localparam logic [1:0]  PHASE_LATCH = 2'(LATCH_CYCLES - 1);

    localparam logic [15:0] ADDR_FIRST  = 16'h0000;
    localparam logic [15:0] ADDR_LAST   = 16'hFFFF;
    localparam logic [3:0]  GROUP_FIRST = 4'h0;
    localparam logic [3:0]  GROUP_LAST  = 4'hF;
    localparam logic        RESULT_PASS = 1'h1;
    localparam logic        RESULT_FAIL = 1'h0;

    // strap levels seen while the reset pin is low
    localparam logic        RDO_PROGRAM_STORE_STROBE_N  = 1'h0;
    localparam logic        RDO_ALE     = 1'h1;
    localparam logic        RDO_EA_N    = 1'h0;
    localparam logic        CMP_PROGRAM_STORE_STROBE_N  = 1'h0;
    localparam logic        CMP_ALE     = 1'h0;
    localparam logic        CMP_EA_N    = 1'h1;

    localparam int FIFO_WIDTH = 24;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W     = 28;

    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_RUN,
        MODE_READOUT,
        MODE_COMPARE,
        MODE_DONE
    } mode_t;

endpackage : rom_verify_pkg

/* File: tb/rom_verify_modes_tb.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module rom_verify_modes_tb;
    import rom_verify_pkg::*;
    logic        ref_clk_i = 1'h0;
    logic        sys_rst_i = 1'h1;
    logic        reset_pin_n = 1'h0;
    logic        strap_program_store_strobe_n = 1'h1;
    logic        strap_ale = 1'h0;
    logic        ea_n = 1'h1;
    logic        rom_prot = 1'h0;
    logic        cmp = 1'h0;
    logic        bad_en = 1'h0;
    logic [15:0] bad_addr = 16'h0000;
    logic [7:0]  p1 = 8'h00;
    logic [7:0]  p2 = 8'h00;
    int          errors = 0;
    int          compares = 0;
    wire         program_store_strobe_o, program_store_strobe_oe, ale_o, ale_oe, p0_oe, result, done;
    wire         program_store_strobe_w, ale_w;
    wire  [7:0]  p0_o, p0_w, t_data, rom_data;
    wire  [15:0] rom_addr;
    wire  [16:0] pulses;

    assign program_store_strobe_w = program_store_strobe_oe ? program_store_strobe_o : strap_program_store_strobe_n;
    assign ale_w  = ale_oe ? ale_o : strap_ale;
    // port 0 lines are pulled up whenever nobody drives them
    assign p0_w   = p0_oe ? p0_o : (cmp ? t_data : 8'hFF);

    always #10 ref_clk_i = ~ref_clk_i;

    // program store answers in the cycle in which its address stands
    assign rom_data = rom_addr[7:0] ^ rom_addr[15:8] ^ 8'hA5;

    rom_verify_modes uut (
        .ref_clk_i                  (ref_clk_i),
        .sys_rst_i                  (sys_rst_i),
        .reset_pin_n_i              (reset_pin_n),
        .program_store_strobe_n_i   (program_store_strobe_w),
        .program_store_strobe_n_o   (program_store_strobe_o),
        .program_store_strobe_oe_o  (program_store_strobe_oe),
        .address_latch_strobe_i     (ale_w),
        .address_latch_strobe_o     (ale_o),
        .address_latch_strobe_oe_o  (ale_oe),
        .external_access_select_n_i (ea_n),
        .port0_i                    (p0_w),
        .port0_o                    (p0_o),
        .port0_oe_o                 (p0_oe),
        .port1_i                    (p1),
        .port2_i                    (p2),
        .rom_protected_i            (rom_prot),
        .rom_addr_o                 (rom_addr),
        .rom_data_i                 (rom_data),
        .verify_result_pin_o        (result),
        .verify_done_o              (done)
    );

    verify_tester partner (
        .clk_i      (ref_clk_i),
        .rst_i      (~reset_pin_n),
        .ale_i      (ale_o),
        .bad_en_i   (bad_en),
        .bad_addr_i (bad_addr),
        .data_o     (t_data),
        .pulses_o   (pulses)
    );

    function automatic logic [7:0] exp_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : exp_byte

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // straps are held while the reset pin is low, long enough for the sync
    task automatic enter_mode(input logic rd, input logic prot);
        @(posedge ref_clk_i);
        reset_pin_n  <= 1'h0;
        strap_program_store_strobe_n <= 1'h0;
        strap_ale    <= rd;
        ea_n         <= ~rd;
        rom_prot     <= prot;
        cmp          <= ~rd;
        repeat (5) @(posedge ref_clk_i);
        reset_pin_n  <= 1'h1;
        repeat (4) @(posedge ref_clk_i);
    endtask : enter_mode

    task automatic wait_pulses(input int n);
        int i;
        for (i = 0; i < 2000 && pulses < n; i++) begin
            @(posedge ref_clk_i);
        end
        if (pulses < n) begin
            errors++;
            $display("BAD %0t strobe count stuck", $time);
            final_report();
        end
    endtask : wait_pulses

    task automatic check_reset();
        `CHK(p0_oe, 1'h0)
        `CHK(ale_oe, 1'h0)
        `CHK(program_store_strobe_oe, 1'h0)
        `CHK(ale_o, 1'h0)
        `CHK(program_store_strobe_o, 1'h1)
        `CHK(result, RESULT_PASS)
        `CHK(done, 1'h0)
        // no test straps: released pin must leave every pin undriven
        reset_pin_n <= 1'h1;
        repeat (6) @(posedge ref_clk_i);
        `CHK(ale_oe, 1'h0)
        `CHK(program_store_strobe_oe, 1'h0)
        `CHK(p0_oe, 1'h0)
    endtask : check_reset

    task automatic check_readout();
        logic [15:0] addrs [4];
        addrs = '{16'h0000, 16'hFFFF, 16'h1234, 16'h00FF};
        enter_mode(1'h1, 1'h0);
        foreach (addrs[i]) begin
            p1 <= addrs[i][7:0];
            p2 <= addrs[i][15:8];
            repeat (6) @(posedge ref_clk_i);
            `CHK(p0_o, exp_byte(addrs[i]))
            `CHK(p0_oe, 1'h1)
            `CHK(rom_addr, addrs[i])
        end
        // protected contents must never reach port 0
        enter_mode(1'h1, 1'h1);
        repeat (6) @(posedge ref_clk_i);
        `CHK(p0_oe, 1'h0)
    endtask : check_readout

    task automatic check_compare_clean();
        enter_mode(1'h0, 1'h0);
        `CHK(ale_oe, 1'h1)
        `CHK(p0_oe, 1'h0)
        wait_pulses(6);
        // any 30 cycles hold exactly ten strobe pulses
        repeat (30) @(posedge ref_clk_i);
        `CHK(pulses, 17'h00010)
        wait_pulses(40);
        `CHK(result, RESULT_PASS)
        `CHK(done, 1'h0)
        `CHK(program_store_strobe_o, 1'h1)
    endtask : check_compare_clean

    task automatic check_compare_error();
        bad_en   <= 1'h1;
        bad_addr <= 16'h0013;
        // protected contents stay checkable through compare
        enter_mode(1'h0, 1'h1);
        wait_pulses(30);
        // the bad byte is latched but its group has not closed yet
        `CHK(result, RESULT_PASS)
        wait_pulses(36);
        `CHK(result, RESULT_FAIL)
        wait_pulses(70);
        `CHK(result, RESULT_FAIL)
    endtask : check_compare_error

    initial begin
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'h0;
        @(posedge ref_clk_i);
        check_reset();
        check_readout();
        check_compare_clean();
        check_compare_error();
        final_report();
    end
endmodule : rom_verify_modes_tb

/* File: tb/verify_tester.sv */
`timescale 1ns/1ns
module verify_tester (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ale_i,
    input  wire logic        bad_en_i,
    input  wire logic [15:0] bad_addr_i,
    output logic      [7:0]  data_o,
    output logic      [16:0] pulses_o
);
    logic [16:0] idx;

    // counter on clk_i that adds one for each cycle with the strobe high, as an outside address counter would count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulses_o <= 17'h00000;
        end else begin
            pulses_o <= pulses_o + {16'h0000, ale_i};
        end
    end

    // byte follows the strobe at once, so it is settled long before the latch
    always_comb begin
        idx = pulses_o + {16'h0000, ale_i};
        idx = (idx == 17'h00000) ? 17'h00000 : idx - 17'h00001;
        data_o = idx[7:0] ^ idx[15:8] ^ 8'hA5;
        // a wrong byte only when a scenario asks for one
        if (bad_en_i && idx[15:0] == bad_addr_i) begin
            data_o = data_o ^ 8'h01;
        end
    end
endmodule : verify_tester
